// file: iod_pkg.sv
// Package: opcode codes, flag masks, clock counts and carriers for the integer decode block.
// Assumes one processor clock; every count is in clocks of that clock.
package iod_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int CNT_W = 12; // Largest count is 6+4*255 = 1026

	////////////////////////////////////////////////////////////////////////////////
	// Opcode bytes and opcode patterns
	localparam logic [7:0] OPC_CARRY_INV = 8'hf5; // Carry flag invert
	localparam logic [7:0] OPC_TWO_BYTE = 8'h0f; // Escape to second opcode byte
	localparam logic [7:0] OPC_ADJ_ADD = 8'h27; // Decimal adjust after add
	localparam logic [7:0] OPC_ADJ_SUB = 8'h2f; // Decimal adjust after subtract
	localparam logic [7:0] OPC_HALT = 8'hf4; // Halt
	localparam logic [7:0] OPC_FRAME = 8'hc8; // Stack frame entry
	localparam logic [7:0] OPC_WIDEN_EXT = 8'h98; // Word to doubleword, extended
	localparam logic [7:0] OPC_WIDEN = 8'h99; // Word to doubleword
	localparam logic [5:0] PAT_CMP_REGMEM = 6'h0e; // 38..3b, bits 7:2
	localparam logic [6:0] PAT_CMP_ACC = 7'h1e; // 3c/3d, bits 7:1
	localparam logic [5:0] PAT_IMM_GROUP = 6'h20; // 80..83, bits 7:2
	localparam logic [6:0] PAT_STR_CMP = 7'h53; // a6/a7, bits 7:1
	localparam logic [6:0] PAT_SWAP_EXT = 7'h58; // Second byte b0/b1, bits 7:1
	localparam logic [6:0] PAT_GROUP_FE = 7'h7f; // fe/ff, bits 7:1
	localparam logic [6:0] PAT_GROUP_F6 = 7'h7b; // f6/f7, bits 7:1
	localparam logic [4:0] PAT_SHORT_SUB1 = 5'h09; // 48..4f, bits 7:3
	localparam logic [1:0] MOD_REGISTER = 2'h3; // Mod field for register operand
	localparam logic [2:0] REG_CMP_IMM = 3'h7; // Compare immediate in 80..83
	localparam logic [2:0] REG_SUB_ONE = 3'h1; // Decrement in fe/ff
	localparam logic [2:0] REG_UQUOT = 3'h6; // Unsigned divide in f6/f7
	localparam logic [2:0] REG_SQUOT = 3'h7; // Signed divide in f6/f7
	localparam int BIT_DIR = 1; // Direction bit of 38..3b
	localparam int BIT_W = 0; // Width bit

	////////////////////////////////////////////////////////////////////////////////
	// Clock counts
	localparam logic [CNT_W-1:0] C_ONE = 12'h001;
	localparam logic [CNT_W-1:0] C_MEM_HIT = 12'h003;
	localparam logic [CNT_W-1:0] C_MEM_MISS = 12'h005;
	localparam logic [CNT_W-1:0] C_ADJ = 12'h004;
	localparam logic [CNT_W-1:0] C_SWAP_REG = 12'h005;
	localparam logic [CNT_W-1:0] C_SWAP_HIT = 12'h007;
	localparam logic [CNT_W-1:0] C_SWAP_MISS = 12'h008;
	localparam logic [CNT_W-1:0] C_STR_HIT = 12'h007;
	localparam logic [CNT_W-1:0] C_STR_MISS = 12'h008;
	localparam logic [CNT_W-1:0] C_WIDEN_EXT = 12'h003;
	localparam logic [CNT_W-1:0] C_HALT = 12'h003;
	localparam logic [CNT_W-1:0] C_UQ_B_REG = 12'h00e;
	localparam logic [CNT_W-1:0] C_UQ_B_HIT = 12'h00f;
	localparam logic [CNT_W-1:0] C_UQ_B_MISS = 12'h011;
	localparam logic [CNT_W-1:0] C_UQ_W_REG = 12'h016;
	localparam logic [CNT_W-1:0] C_UQ_W_HIT = 12'h017;
	localparam logic [CNT_W-1:0] C_UQ_W_MISS = 12'h018;
	localparam logic [CNT_W-1:0] C_UQ_D_REG = 12'h026;
	localparam logic [CNT_W-1:0] C_UQ_D_HIT = 12'h027;
	localparam logic [CNT_W-1:0] C_UQ_D_MISS = 12'h028;
	localparam logic [CNT_W-1:0] C_SQ_B_REG = 12'h013;
	localparam logic [CNT_W-1:0] C_SQ_B_HIT = 12'h014;
	localparam logic [CNT_W-1:0] C_SQ_B_MISS = 12'h016;
	localparam logic [CNT_W-1:0] C_SQ_W_REG = 12'h01b;
	localparam logic [CNT_W-1:0] C_SQ_W_HIT = 12'h01c;
	localparam logic [CNT_W-1:0] C_SQ_W_MISS = 12'h01d;
	localparam logic [CNT_W-1:0] C_SQ_D_REG = 12'h02b;
	localparam logic [CNT_W-1:0] C_SQ_D_HIT = 12'h02c;
	localparam logic [CNT_W-1:0] C_SQ_D_MISS = 12'h02f;
	localparam logic [CNT_W-1:0] C_FRAME_L0 = 12'h007;
	localparam logic [CNT_W-1:0] C_FRAME_L0_MISS = 12'h00a;
	localparam logic [CNT_W-1:0] C_FRAME_L1 = 12'h00a;
	localparam logic [CNT_W-1:0] C_FRAME_BASE = 12'h006;
	localparam logic [CNT_W-1:0] C_FRAME_STEP = 12'h004;
	localparam logic [7:0] LEVEL_ZERO = 8'h00;
	localparam logic [7:0] LEVEL_ONE = 8'h01;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic of; // Overflow
		logic sf; // Sign
		logic zf; // Zero
		logic af; // Auxiliary carry
		logic pf; // Parity
		logic cf; // Carry
	} iod_flags_t;

	localparam iod_flags_t FLAGS_NONE = 6'h00;
	localparam iod_flags_t FLAGS_ARITH = 6'h3f; // All six arithmetic flags
	localparam iod_flags_t FLAGS_ADJ = 6'h1f; // Sign, zero, aux, parity, carry
	localparam iod_flags_t FLAGS_NO_CARRY = 6'h3e; // All but carry
	localparam iod_flags_t FLAGS_CARRY = 6'h01; // Carry only

	typedef enum logic [3:0] {
		IOD_OP_ILLEGAL,
		IOD_OP_CARRY_FLAG_INVERT,
		IOD_OP_COMPARE_INTEGERS,
		IOD_OP_COMPARE_STRING,
		IOD_OP_COMPARE_AND_SWAP,
		IOD_OP_WIDEN,
		IOD_OP_BCD_ADJUST_AFTER_ADD,
		IOD_OP_BCD_ADJUST_AFTER_SUBTRACT,
		IOD_OP_SUBTRACT_ONE,
		IOD_OP_UNSIGNED_QUOTIENT,
		IOD_OP_SIGNED_QUOTIENT,
		IOD_OP_FRAME_ENTRY,
		IOD_OP_HALT
	} iod_op_t;

	typedef enum logic [1:0] {
		IOD_SIZE_BYTE,
		IOD_SIZE_WORD,
		IOD_SIZE_DWORD
	} iod_size_t;

	typedef struct packed {
		logic [7:0] opcode; // First opcode byte
		logic [7:0] ext_opcode; // Byte after 0f escape
		logic [7:0] modrm; // Mode/reg/rm byte
		logic [7:0] level; // Nesting level of frame entry
		logic opsize_32; // Full-width operand size in force
		logic cache_hit; // Memory operand present in cache
	} iod_req_t;

	typedef struct packed {
		iod_op_t op; // Decoded operation
		iod_size_t size; // Operand size
		iod_flags_t flag_write; // Flags that the operation updates
		logic carry_invert; // Carry is inverted, not computed
		logic writes_operand; // Destination is written
		logic mem_operand; // Operand lives in memory
		logic [CNT_W-1:0] cycles; // Execution clocks
	} iod_dec_t;

endpackage

////////////////////////////////////////////////////////////////////////////////
// Execution timer: holds busy for a loaded number of clocks.
`timescale 1ns/100ps
module iod_exec_timer #(
	parameter int CNT_W = 12
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [CNT_W-1:0] count,
	output logic busy,
	output logic done
);
	logic [CNT_W-1:0] remain_reg; // Clocks still to run

	// Load on start, then count down to zero
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			remain_reg <= '0;
		end else if (start) begin
			remain_reg <= count;
		end else if (remain_reg != '0) begin
			remain_reg <= remain_reg - 1'b1;
		end
	end

	assign busy = (remain_reg != '0); // Any clock left
	assign done = (remain_reg == CNT_W'(1)); // Last clock of the operation
endmodule

// file: iod_decode_top.sv
// Integer instruction decoder with execution timing for one slice of the instruction set.
// Assumes request fields come from logic on sys_clk; no synchronisers are needed.
`timescale 1ns/100ps
module iod_decode_top (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire iod_pkg::iod_req_t req,
	input wire logic wake,
	output iod_pkg::iod_dec_t dec_out,
	output logic exec_busy,
	output logic exec_done,
	output logic halted
);
	import iod_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	iod_dec_t dec_next; // Combinational decode of the request
	iod_dec_t dec_reg; // Decode held for the running operation
	logic halted_reg; // Halt has completed, waiting for wake
	logic halt_running_reg; // The running operation is the halt
	logic accept; // Request taken this edge
	logic timer_busy; // Timer still counting
	logic timer_done; // Last clock of the operation
	logic [1:0] mod_f; // Mode field of modrm
	logic [2:0] reg_f; // Reg field of modrm
	logic is_mem; // Operand is in memory
	logic miss; // Memory operand missed the cache
	iod_size_t size_w; // Size from width bit and operand size

	////////////////////////////////////////////////////////////////////////////////
	// Count selection
	// Register, hit and miss counts chosen by operand place and cache state
	function automatic logic [CNT_W-1:0] pick(
		input logic mem,
		input logic cmiss,
		input logic [CNT_W-1:0] c_reg,
		input logic [CNT_W-1:0] c_hit,
		input logic [CNT_W-1:0] c_miss
	);
		logic [CNT_W-1:0] r;
		r = c_reg;
		if (mem && cmiss) begin
			r = c_miss;
		end else if (mem) begin
			r = c_hit;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Field extraction
	assign mod_f = req.modrm[7:6]; // Same place in one- and two-byte forms
	assign reg_f = req.modrm[5:3];
	assign is_mem = (mod_f != MOD_REGISTER);
	assign miss = is_mem && !req.cache_hit; // Only a memory operand can miss

	// Width bit picks byte; otherwise operand size picks word or doubleword
	always_comb begin
		if (!req.opcode[BIT_W]) begin
			size_w = IOD_SIZE_BYTE;
		end else if (req.opsize_32) begin
			size_w = IOD_SIZE_DWORD;
		end else begin
			size_w = IOD_SIZE_WORD;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decode
	// Unknown encodings decode as illegal with one clock so the pipe never stalls
	always_comb begin
		dec_next = '0;
		dec_next.op = IOD_OP_ILLEGAL;
		dec_next.size = size_w;
		dec_next.flag_write = FLAGS_NONE;
		dec_next.cycles = C_ONE;
		if (req.opcode == OPC_CARRY_INV) begin
			// Only carry changes, and it is inverted
			dec_next.op = IOD_OP_CARRY_FLAG_INVERT;
			dec_next.flag_write = FLAGS_CARRY;
			dec_next.carry_invert = 1'b1;
			dec_next.cycles = C_ONE;
		end else if (req.opcode[7:2] == PAT_CMP_REGMEM) begin
			// Compare never writes its operands
			dec_next.op = IOD_OP_COMPARE_INTEGERS;
			dec_next.flag_write = FLAGS_ARITH;
			dec_next.mem_operand = is_mem;
			dec_next.cycles = pick(is_mem, miss, C_ONE, C_MEM_HIT, C_MEM_MISS);
		end else if (req.opcode[7:1] == PAT_CMP_ACC) begin
			// Immediate against accumulator
			dec_next.op = IOD_OP_COMPARE_INTEGERS;
			dec_next.flag_write = FLAGS_ARITH;
			dec_next.cycles = C_ONE;
		end else if (req.opcode[7:2] == PAT_IMM_GROUP && reg_f == REG_CMP_IMM) begin
			// Other reg values of this group are outside this slice
			dec_next.op = IOD_OP_COMPARE_INTEGERS;
			dec_next.flag_write = FLAGS_ARITH;
			dec_next.mem_operand = is_mem;
			dec_next.cycles = pick(is_mem, miss, C_ONE, C_MEM_HIT, C_MEM_MISS);
		end else if (req.opcode[7:1] == PAT_STR_CMP) begin
			// String compare always touches memory
			dec_next.op = IOD_OP_COMPARE_STRING;
			dec_next.flag_write = FLAGS_ARITH;
			dec_next.mem_operand = 1'b1;
			dec_next.cycles = req.cache_hit ? C_STR_HIT : C_STR_MISS;
		end else if (req.opcode == OPC_TWO_BYTE && req.ext_opcode[7:1] == PAT_SWAP_EXT) begin
			// Width bit sits in the second opcode byte here
			dec_next.op = IOD_OP_COMPARE_AND_SWAP;
			dec_next.size = !req.ext_opcode[BIT_W] ? IOD_SIZE_BYTE :
				(req.opsize_32 ? IOD_SIZE_DWORD : IOD_SIZE_WORD);
			dec_next.flag_write = FLAGS_ARITH;
			dec_next.writes_operand = 1'b1;
			dec_next.mem_operand = is_mem;
			dec_next.cycles = pick(is_mem, miss, C_SWAP_REG, C_SWAP_HIT, C_SWAP_MISS);
		end else if (req.opcode == OPC_WIDEN || req.opcode == OPC_WIDEN_EXT) begin
			// Sign extension of the accumulator, no flags
			dec_next.op = IOD_OP_WIDEN;
			dec_next.writes_operand = 1'b1;
			dec_next.cycles = (req.opcode == OPC_WIDEN) ? C_ONE : C_WIDEN_EXT;
		end else if (req.opcode == OPC_ADJ_ADD) begin
			// Acts on the low accumulator byte
			dec_next.op = IOD_OP_BCD_ADJUST_AFTER_ADD;
			dec_next.size = IOD_SIZE_BYTE;
			dec_next.flag_write = FLAGS_ADJ;
			dec_next.writes_operand = 1'b1;
			dec_next.cycles = C_ADJ;
		end else if (req.opcode == OPC_ADJ_SUB) begin
			// Acts on the low accumulator byte
			dec_next.op = IOD_OP_BCD_ADJUST_AFTER_SUBTRACT;
			dec_next.size = IOD_SIZE_BYTE;
			dec_next.flag_write = FLAGS_ADJ;
			dec_next.writes_operand = 1'b1;
			dec_next.cycles = C_ADJ;
		end else if (req.opcode[7:1] == PAT_GROUP_FE && reg_f == REG_SUB_ONE) begin
			// Carry is kept, so the mask leaves it out
			dec_next.op = IOD_OP_SUBTRACT_ONE;
			dec_next.flag_write = FLAGS_NO_CARRY;
			dec_next.writes_operand = 1'b1;
			dec_next.mem_operand = is_mem;
			dec_next.cycles = pick(is_mem, miss, C_ONE, C_MEM_HIT, C_MEM_MISS);
		end else if (req.opcode[7:3] == PAT_SHORT_SUB1) begin
			// Short register form, register in opcode bits
			dec_next.op = IOD_OP_SUBTRACT_ONE;
			dec_next.size = req.opsize_32 ? IOD_SIZE_DWORD : IOD_SIZE_WORD;
			dec_next.flag_write = FLAGS_NO_CARRY;
			dec_next.writes_operand = 1'b1;
			dec_next.cycles = C_ONE;
		end else if (req.opcode[7:1] == PAT_GROUP_F6 && reg_f == REG_UQUOT) begin
			// Flags are left undefined, so none are written
			dec_next.op = IOD_OP_UNSIGNED_QUOTIENT;
			dec_next.writes_operand = 1'b1;
			dec_next.mem_operand = is_mem;
			unique case (size_w)
				IOD_SIZE_BYTE: dec_next.cycles = pick(is_mem, miss, C_UQ_B_REG, C_UQ_B_HIT, C_UQ_B_MISS);
				IOD_SIZE_WORD: dec_next.cycles = pick(is_mem, miss, C_UQ_W_REG, C_UQ_W_HIT, C_UQ_W_MISS);
				IOD_SIZE_DWORD: dec_next.cycles = pick(is_mem, miss, C_UQ_D_REG, C_UQ_D_HIT, C_UQ_D_MISS);
				default: dec_next.cycles = C_ONE;
			endcase
		end else if (req.opcode[7:1] == PAT_GROUP_F6 && reg_f == REG_SQUOT) begin
			// Signed form pays the extra sign fix-up clocks
			dec_next.op = IOD_OP_SIGNED_QUOTIENT;
			dec_next.writes_operand = 1'b1;
			dec_next.mem_operand = is_mem;
			unique case (size_w)
				IOD_SIZE_BYTE: dec_next.cycles = pick(is_mem, miss, C_SQ_B_REG, C_SQ_B_HIT, C_SQ_B_MISS);
				IOD_SIZE_WORD: dec_next.cycles = pick(is_mem, miss, C_SQ_W_REG, C_SQ_W_HIT, C_SQ_W_MISS);
				IOD_SIZE_DWORD: dec_next.cycles = pick(is_mem, miss, C_SQ_D_REG, C_SQ_D_HIT, C_SQ_D_MISS);
				default: dec_next.cycles = C_ONE;
			endcase
		end else if (req.opcode == OPC_FRAME) begin
			// Only level zero has a separate miss count
			dec_next.op = IOD_OP_FRAME_ENTRY;
			dec_next.writes_operand = 1'b1;
			dec_next.mem_operand = 1'b1;
			if (req.level == LEVEL_ZERO) begin
				dec_next.cycles = req.cache_hit ? C_FRAME_L0 : C_FRAME_L0_MISS;
			end else if (req.level == LEVEL_ONE) begin
				dec_next.cycles = C_FRAME_L1;
			end else begin
				dec_next.cycles = CNT_W'(C_FRAME_BASE + C_FRAME_STEP * CNT_W'(req.level));
			end
		end else if (req.opcode == OPC_HALT) begin
			// Halt runs its clocks, then holds off requests
			dec_next.op = IOD_OP_HALT;
			dec_next.cycles = C_HALT;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Handshake
	// One operation at a time; nothing is taken while halted
	assign req_ready = !timer_busy && !halted_reg;
	assign accept = req_valid && req_ready;

	// Timer for the decoded clock count
	iod_exec_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.start(accept),
		.count(dec_next.cycles),
		.busy(timer_busy),
		.done(timer_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decode register
	// Held until the next request so the executing unit sees it throughout
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dec_reg <= '0;
		end else if (accept) begin
			dec_reg <= dec_next;
		end
	end

	// Marks whether the running operation is the halt
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			halt_running_reg <= 1'b0;
		end else if (accept) begin
			halt_running_reg <= (dec_next.op == IOD_OP_HALT);
		end
	end

	// Halted state: completion sets it, wake clears it; set wins
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			halted_reg <= 1'b0;
		end else if (timer_done && halt_running_reg) begin
			halted_reg <= 1'b1;
		end else if (wake) begin
			halted_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign dec_out = dec_reg;
	assign exec_busy = timer_busy;
	assign exec_done = timer_done;
	assign halted = halted_reg;
endmodule

// file: iod_decode_chk.sv
// Checker for the integer decode block: flag masks, clock counts and busy/done timing.
// Assumes it is bound to iod_decode_top and sees only that module's ports.
`timescale 1ns/100ps
module iod_decode_chk
	import iod_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire iod_pkg::iod_req_t req,
	input wire logic wake,
	input wire iod_pkg::iod_dec_t dec_out,
	input wire logic exec_busy,
	input wire logic exec_done,
	input wire logic halted
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////////
	// Helper logic
	logic take; // Request accepted at this edge
	logic on_mem; // Operand lives in memory
	logic [CNT_W-1:0] run_reg; // Clocks elapsed in the running operation
	assign take = req_valid && req_ready;
	assign on_mem = req.modrm[7:6] != MOD_REGISTER;

	// Count clocks from accept; a count register avoids long repetitions
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			run_reg <= '0;
		end else if (take) begin
			run_reg <= 12'h001;
		end else if (exec_busy) begin
			run_reg <= run_reg + 12'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Named steps
	sequence s_take(logic [7:0] opc);
		take && req.opcode == opc;
	endsequence
	sequence s_one_clock;
		exec_busy && exec_done ##1 !exec_busy && req_ready;
	endsequence
	sequence s_four_clock;
		(exec_busy && !exec_done) [*3] ##1 exec_busy && exec_done ##1 !exec_busy;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_carry_flip_one: assert property (s_take(OPC_CARRY_INV) |=>
		(dec_out.flag_write == FLAGS_CARRY && dec_out.carry_invert) ##0 s_one_clock)
		else $error("carry invert mask or timing wrong");
	a_cmp_reg_one: assert property (take && req.opcode[7:2] == PAT_CMP_REGMEM && !on_mem |=>
		(dec_out.flag_write == FLAGS_ARITH && !dec_out.writes_operand) ##0 s_one_clock)
		else $error("register compare wrong");
	a_cmp_imm_mem: assert property (take && req.opcode[7:2] == PAT_IMM_GROUP && req.modrm[5:3] == REG_CMP_IMM
		&& on_mem |=> dec_out.cycles == ($past(req.cache_hit) ? C_MEM_HIT : C_MEM_MISS))
		else $error("immediate compare count wrong");
	a_swap_count: assert property (s_take(OPC_TWO_BYTE) ##0 req.ext_opcode[7:1] == PAT_SWAP_EXT |=>
		dec_out.flag_write == FLAGS_ARITH && dec_out.cycles == (!$past(on_mem) ? C_SWAP_REG :
		($past(req.cache_hit) ? C_SWAP_HIT : C_SWAP_MISS)))
		else $error("compare and swap wrong");
	a_adjust_add_time: assert property (s_take(OPC_ADJ_ADD) |=>
		dec_out.flag_write == FLAGS_ADJ ##0 s_four_clock)
		else $error("adjust after add wrong");
	a_adjust_sub_time: assert property (s_take(OPC_ADJ_SUB) |=>
		dec_out.flag_write == FLAGS_ADJ ##0 s_four_clock)
		else $error("adjust after subtract wrong");
	a_sub_keep_carry: assert property (take && req.opcode[7:1] == PAT_GROUP_FE && req.modrm[5:3] == REG_SUB_ONE
		|=> !dec_out.flag_write.cf && dec_out.flag_write.zf && dec_out.op == IOD_OP_SUBTRACT_ONE)
		else $error("decrement touches carry");
	a_uquot_byte_reg: assert property (s_take(8'hf6) ##0 req.modrm[5:3] == REG_UQUOT && !on_mem
		|=> dec_out.cycles == C_UQ_B_REG && (exec_busy && !exec_done) [*8])
		else $error("unsigned byte divide count wrong");
	a_squot_word_reg: assert property (s_take(8'hf7) ##0 req.modrm[5:3] == REG_SQUOT && !on_mem
		&& !req.opsize_32 |=> dec_out.cycles == C_SQ_W_REG)
		else $error("signed word divide count wrong");
	a_frame_level: assert property (s_take(OPC_FRAME) ##0 req.level > LEVEL_ONE |=>
		dec_out.cycles == C_FRAME_BASE + {2'h0, $past(req.level), 2'h0})
		else $error("frame entry count wrong");
	a_done_count: assert property (exec_done |-> run_reg == dec_out.cycles)
		else $error("done pulse not at the decoded count");
endmodule

bind iod_decode_top iod_decode_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid),
	.req_ready(req_ready), .req(req), .wake(wake), .dec_out(dec_out), .exec_busy(exec_busy),
	.exec_done(exec_done), .halted(halted));

// file: iod_decode_tb.sv
// Self-checking bench for the integer decode block: corner table, random requests, halt.
// Assumes the checker file is compiled with it; inputs change at the falling edge.
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
	cmp_count++; \
	if ((ex) !== (got)) begin \
		n_errors++; \
		$display("BAD %s expected %0h seen %0h", nm, ex, got); \
	end
module testbench;
	import iod_pkg::*;
	typedef struct packed {
		iod_op_t op; // Expected operation
		iod_flags_t fl; // Expected flag mask
		logic [CNT_W-1:0] cyc; // Expected clocks
	} iod_exp_t;

	////////////////////////////////////////////////////////////////////////////////
	// Signals and tables
	logic sys_clk = 1'b0; // 50 ns clock
	logic sys_rst = 1'b1; // Held at start
	logic req_valid = 1'b0; // Request strobe
	logic wake = 1'b0; // Leaves halt
	iod_req_t req = '0; // Request fields
	logic req_ready; // Design ready
	iod_dec_t dec_out; // Design decode
	logic exec_busy; // Operation running
	logic exec_done; // Last clock
	logic halted; // Halt state
	int n_errors = 0; // Mismatches
	int cmp_count = 0; // Comparisons
	integer seed = 32'h6e32; // Fixed seed
	logic [31:0] rnd; // Random word
	int k; // Random kind
	iod_req_t r; // Built request
	localparam logic [11:0] T_RM [3] = '{12'h001, 12'h003, 12'h005}; // Reg, hit, miss
	localparam logic [11:0] T_SW [3] = '{12'h005, 12'h007, 12'h008};
	localparam logic [11:0] T_UQ [3][3] = '{'{12'h00e, 12'h00f, 12'h011}, '{12'h016, 12'h017, 12'h018},
		'{12'h026, 12'h027, 12'h028}};
	localparam logic [11:0] T_SQ [3][3] = '{'{12'h013, 12'h014, 12'h016}, '{12'h01b, 12'h01c, 12'h01d},
		'{12'h02b, 12'h02c, 12'h02f}};
	localparam logic [7:0] PICK [9] = '{8'hf5, 8'h38, 8'h80, 8'h0f, 8'h27, 8'h2f, 8'hfe, 8'hf6, 8'hc8};
	localparam logic [7:0] MASK [9] = '{8'h00, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
	// Corner cases: opcode, second byte, modrm, level, full width, cache hit
	localparam iod_req_t DIR [19] = '{
		'{8'hf5, 8'h00, 8'hc0, 8'h00, 1'b0, 1'b1}, '{8'h38, 8'h00, 8'hc0, 8'h00, 1'b0, 1'b1},
		'{8'h3b, 8'h00, 8'h05, 8'h00, 1'b1, 1'b1}, '{8'h83, 8'h00, 8'h38, 8'h00, 1'b0, 1'b0},
		'{8'h0f, 8'hb1, 8'hc0, 8'h00, 1'b1, 1'b1}, '{8'h0f, 8'hb0, 8'h00, 8'h00, 1'b0, 1'b0},
		'{8'h27, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0}, '{8'h2f, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1},
		'{8'hff, 8'h00, 8'h08, 8'h00, 1'b0, 1'b0}, '{8'hf6, 8'h00, 8'hf0, 8'h00, 1'b0, 1'b1},
		'{8'hf7, 8'h00, 8'hf8, 8'h00, 1'b0, 1'b1}, '{8'hf7, 8'h00, 8'h38, 8'h00, 1'b1, 1'b0},
		'{8'hc8, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0}, '{8'hc8, 8'h00, 8'h00, 8'hff, 1'b0, 1'b1},
		'{8'h3c, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0}, '{8'ha7, 8'h00, 8'hc0, 8'h00, 1'b1, 1'b0},
		'{8'h98, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1}, '{8'h99, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1},
		'{8'h4b, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0}};

	iod_decode_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .wake(wake), .dec_out(dec_out), .exec_busy(exec_busy), .exec_done(exec_done),
		.halted(halted));

	////////////////////////////////////////////////////////////////////////////////
	// Reference decode from the instruction timing table
	function automatic iod_exp_t ref_model(iod_req_t q);
		int col;
		int sz;
		logic [11:0] fr;
		col = (q.modrm[7:6] == 2'h3) ? 0 : (q.cache_hit ? 1 : 2);
		sz = !q.opcode[0] ? 0 : (q.opsize_32 ? 2 : 1);
		fr = q.level == 8'h00 ? (q.cache_hit ? 12'h007 : 12'h00a) : (q.level == 8'h01 ? 12'h00a :
			12'h006 + {2'h0, q.level, 2'h0});
		ref_model = '{IOD_OP_ILLEGAL, FLAGS_NONE, 12'h001};
		case (1'b1)
			q.opcode == 8'hf5: ref_model = '{IOD_OP_CARRY_FLAG_INVERT, FLAGS_CARRY, 12'h001};
			q.opcode[7:2] == 6'h0e: ref_model = '{IOD_OP_COMPARE_INTEGERS, FLAGS_ARITH, T_RM[col]};
			q.opcode[7:2] == 6'h20 && q.modrm[5:3] == 3'h7:
				ref_model = '{IOD_OP_COMPARE_INTEGERS, FLAGS_ARITH, T_RM[col]};
			q.opcode == 8'h0f && q.ext_opcode[7:1] == 7'h58:
				ref_model = '{IOD_OP_COMPARE_AND_SWAP, FLAGS_ARITH, T_SW[col]};
			q.opcode == 8'h27: ref_model = '{IOD_OP_BCD_ADJUST_AFTER_ADD, FLAGS_ADJ, 12'h004};
			q.opcode == 8'h2f: ref_model = '{IOD_OP_BCD_ADJUST_AFTER_SUBTRACT, FLAGS_ADJ, 12'h004};
			q.opcode[7:1] == 7'h7f && q.modrm[5:3] == 3'h1:
				ref_model = '{IOD_OP_SUBTRACT_ONE, FLAGS_NO_CARRY, T_RM[col]};
			q.opcode[7:1] == 7'h7b && q.modrm[5:3] == 3'h6:
				ref_model = '{IOD_OP_UNSIGNED_QUOTIENT, FLAGS_NONE, T_UQ[sz][col]};
			q.opcode[7:1] == 7'h7b && q.modrm[5:3] == 3'h7:
				ref_model = '{IOD_OP_SIGNED_QUOTIENT, FLAGS_NONE, T_SQ[sz][col]};
			q.opcode == 8'hc8: ref_model = '{IOD_OP_FRAME_ENTRY, FLAGS_NONE, fr};
			q.opcode == 8'hf4: ref_model = '{IOD_OP_HALT, FLAGS_NONE, 12'h003};
			q.opcode[7:1] == 7'h1e: ref_model = '{IOD_OP_COMPARE_INTEGERS, FLAGS_ARITH, 12'h001};
			q.opcode[7:1] == 7'h53:
				ref_model = '{IOD_OP_COMPARE_STRING, FLAGS_ARITH, q.cache_hit ? 12'h007 : 12'h008};
			q.opcode == 8'h98: ref_model = '{IOD_OP_WIDEN, FLAGS_NONE, 12'h003};
			q.opcode == 8'h99: ref_model = '{IOD_OP_WIDEN, FLAGS_NONE, 12'h001};
			q.opcode[7:3] == 5'h09: ref_model = '{IOD_OP_SUBTRACT_ONE, FLAGS_NO_CARRY, 12'h001};
			default: ;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// One request: wait for ready, then measure busy and done against the reference
	task automatic issue(iod_req_t q);
		iod_exp_t e;
		int n;
		int done_at;
		logic xw;
		logic xm;
		e = ref_model(q);
		req = q;
		req_valid = 1'b1;
		n = 0;
		while (req_ready !== 1'b1 && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 2000) begin
			$display("BAD ready wait expected 1 seen %0h", req_ready);
			n_errors++;
			complete_run();
		end
		@(negedge sys_clk);
		req_valid = 1'b0;
		`CHK("op", e.op, dec_out.op)
		`CHK("flags", e.fl, dec_out.flag_write)
		`CHK("carry_invert", q.opcode == 8'hf5, dec_out.carry_invert)
		`CHK("cycles", e.cyc, dec_out.cycles)
		// Compares and the carry flip never write an operand
		xw = !(e.op inside {IOD_OP_ILLEGAL, IOD_OP_CARRY_FLAG_INVERT, IOD_OP_COMPARE_INTEGERS,
			IOD_OP_COMPARE_STRING, IOD_OP_HALT});
		// A memory form always costs more than one clock
		xm = e.op inside {IOD_OP_COMPARE_STRING, IOD_OP_FRAME_ENTRY} || (q.modrm[7:6] != 2'h3 && e.cyc != 12'h001
			&& e.op inside {IOD_OP_COMPARE_INTEGERS, IOD_OP_COMPARE_AND_SWAP, IOD_OP_SUBTRACT_ONE,
			IOD_OP_UNSIGNED_QUOTIENT, IOD_OP_SIGNED_QUOTIENT});
		`CHK("writes", xw, dec_out.writes_operand)
		`CHK("mem", xm, dec_out.mem_operand)
		n = 0;
		done_at = 0;
		// Bounded: the longest count is 1026 clocks
		while (exec_busy === 1'b1 && n < 1100) begin
			n++;
			if (exec_done === 1'b1) begin
				done_at += n; // A second pulse spoils the sum
			end
			@(negedge sys_clk);
		end
		`CHK("busy_clocks", int'(e.cyc), n)
		`CHK("done_clock", int'(e.cyc), done_at)
		$display("test opcode %0h modrm %0h clocks %0d end", q.opcode, q.modrm, n);
	endtask

	// Verdict and end of run
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	// Main sequence: reset, corners, random mix, halt with refused request
	initial begin
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		sys_rst = 1'b0;
		`CHK("ready_after_reset", 1'b1, req_ready)
		foreach (DIR[i]) begin
			issue(DIR[i]);
		end
		for (int i = 0; i < 60; i++) begin
			rnd = $random(seed);
			k = rnd[23:20] % 9;
			r = '{PICK[k] | {6'h00, rnd[25:24] & MASK[k][1:0]}, {7'h58, rnd[26]}, rnd[7:0],
				rnd[15:8] & (rnd[16] ? 8'hff : 8'h03), rnd[17], rnd[18]};
			if (k == 2) begin
				r.modrm[5:3] = 3'h7;
			end
			if (k == 6) begin
				r.modrm[5:3] = 3'h1;
			end
			if (k == 7) begin
				r.modrm[5:3] = {2'h3, rnd[27]};
			end
			issue(r);
		end
		// Halt blocks requests until wake
		issue('{OPC_HALT, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1});
		`CHK("halted", 1'b1, halted)
		`CHK("ready_halted", 1'b0, req_ready)
		req = DIR[0];
		req_valid = 1'b1;
		repeat (3) @(negedge sys_clk);
		`CHK("refused_op", IOD_OP_HALT, dec_out.op)
		wake = 1'b1;
		@(negedge sys_clk);
		wake = 1'b0;
		`CHK("halt_cleared", 1'b0, halted)
		issue(DIR[0]);
		complete_run();
	end
endmodule
